// File: hw/literal_move_return_exec.sv
// Purpose: Executes literal loads, accumulator stores, indirect moves, idle, reset, irq return.
// Assumes: Fetch offers one word with INSTR_VALID_I; taken only while READY_O is high.
// Notes: Data memory read answers one cycle after MEM_RE_O.
`timescale 1ns/100ps
module literal_move_return_exec
  import lmr_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Instruction offer
  input wire logic [INSTR_W-1:0] INSTR_I,
  input wire logic INSTR_VALID_I,
  output logic READY_O,
  // Core registers
  output logic [7:0] ACCUM_O,
  output logic [5:0] BANK_SELECT_O,
  output logic [6:0] PAGE_LATCH_O,
  output logic [15:0] PTR0_O,
  output logic [15:0] PTR1_O,
  output logic ZERO_O,
  // Data memory
  output logic [ADDR_W-1:0] MEM_ADDR_O,
  output logic [7:0] MEM_WDATA_O,
  output logic MEM_WE_O,
  output logic MEM_RE_O,
  input wire logic [7:0] MEM_RDATA_I,
  // Stack and program counter
  input wire logic [14:0] STACK_TOP_I,
  output logic STACK_POP_O,
  output logic PC_LOAD_O,
  output logic [14:0] PC_VALUE_O,
  output logic PC_INC_O,
  output logic FLUSH_O,
  // Reset and irq control
  output logic SOFT_RESET_O,
  output logic SOFT_RESET_FLAG_CLR_O,
  output logic [7:0] IRQ_CTRL_SET_O
);
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_LOAD_ISSUE = 3'b001,
    ST_LOAD_CAPT = 3'b010,
    ST_FLUSH = 3'b011,
    ST_RESET_WAIT = 3'b100
  } state_e;

  typedef struct packed {
    state_e state;
    logic [7:0] accum;
    logic [5:0] bank_sel;
    logic [6:0] page_latch;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic zero;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic mem_re;
    logic pop;
    logic pc_load;
    logic [14:0] pc_value;
    logic pc_inc;
    logic flush;
    logic soft_rst;
    logic flag_clr;
    logic [7:0] irq_set;
  } st_s;

  st_s st_ff;
  st_s nxt_st;
  logic accept;
  logic [5:0] op_hi;
  logic is_misc;
  logic is_rel;
  logic ind_sel;
  logic [15:0] sel_ptr;
  logic [15:0] eff_addr;
  logic [15:0] nxt_ptr;

  assign READY_O = (st_ff.state == ST_RUN);
  assign accept = INSTR_VALID_I && READY_O;
  assign op_hi = INSTR_I[13:8];
  assign is_misc = (op_hi == OP_MISC) && !INSTR_I[STORE_FILE_BIT];
  assign is_rel = (op_hi == OP_REL_IND);
  assign ind_sel = is_rel ? INSTR_I[REL_SEL_BIT] : INSTR_I[IND_SEL_BIT];
  assign sel_ptr = ind_sel ? st_ff.ptr1 : st_ff.ptr0;

  ptr_step u_ptr_step (
    .ptr_i(sel_ptr),
    .mode_i(INSTR_I[1:0]),
    .rel_i(is_rel),
    .off_i(INSTR_I[5:0]),
    .eff_o(eff_addr),
    .nxt_ptr_o(nxt_ptr)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.mem_we = 1'b0;
    nxt_st.mem_re = 1'b0;
    nxt_st.pop = 1'b0;
    nxt_st.pc_load = 1'b0;
    nxt_st.pc_inc = 1'b0;
    nxt_st.flush = 1'b0;
    nxt_st.soft_rst = 1'b0;
    nxt_st.flag_clr = 1'b0;
    nxt_st.irq_set = 8'h00;
    case (st_ff.state)
      ST_RUN: begin
        if (accept) begin
          nxt_st.pc_inc = 1'b1;
          if (INSTR_I[13:12] == OP_ACCUM_LIT) begin
            // Bits 11:8 ignored; zeros are the canonical form
            nxt_st.accum = INSTR_I[7:0];
          end else if (op_hi == OP_BANK_LIT) begin
            nxt_st.bank_sel = INSTR_I[5:0];
          end else if (op_hi == OP_PAGE_LIT) begin
            nxt_st.page_latch = INSTR_I[6:0];
          end else if (op_hi == OP_MISC && INSTR_I[STORE_FILE_BIT]) begin
            nxt_st.mem_we = 1'b1;
            nxt_st.mem_wdata = st_ff.accum;
            if (INSTR_I[6:0] == VIRT_PORT0) begin
              nxt_st.mem_addr = st_ff.ptr0;
            end else if (INSTR_I[6:0] == VIRT_PORT1) begin
              nxt_st.mem_addr = st_ff.ptr1;
            end else begin
              nxt_st.mem_addr = {3'b000, st_ff.bank_sel, INSTR_I[6:0]};
            end
          end else if (is_rel || (is_misc && (INSTR_I[6:4] == 3'b001))) begin
            // Zero flag left alone here; only the load capture touches it
            nxt_st.mem_addr = eff_addr;
            if (ind_sel) begin
              nxt_st.ptr1 = nxt_ptr;
            end else begin
              nxt_st.ptr0 = nxt_ptr;
            end
            if (is_rel ? INSTR_I[REL_LOAD_BIT] : (INSTR_I[6:3] == MISC_LOAD_IND)) begin
              nxt_st.mem_re = 1'b1;
              nxt_st.state = ST_LOAD_ISSUE;
            end else begin
              nxt_st.mem_we = 1'b1;
              nxt_st.mem_wdata = st_ff.accum;
            end
          end else if (is_misc && INSTR_I[6:0] == MISC_SOFT_RESET) begin
            // Core halts until the device reset arrives on RESETN_I
            nxt_st.pc_inc = 1'b0;
            nxt_st.soft_rst = 1'b1;
            nxt_st.flag_clr = 1'b1;
            nxt_st.state = ST_RESET_WAIT;
          end else if (is_misc && INSTR_I[6:0] == MISC_IRQ_RETURN) begin
            nxt_st.pc_inc = 1'b0;
            nxt_st.pop = 1'b1;
            nxt_st.pc_load = 1'b1;
            nxt_st.pc_value = STACK_TOP_I;
            nxt_st.irq_set = IRQ_SET_MASK;
            // Flush in the same cycle as the pop and PC load, so the stale fetched word is never taken
            nxt_st.flush = 1'b1;
            nxt_st.state = ST_FLUSH;
          end
          // Idle op and undecoded words only advance the counter
        end
      end
      ST_LOAD_ISSUE: begin
        nxt_st.state = ST_LOAD_CAPT;
      end
      ST_LOAD_CAPT: begin
        nxt_st.accum = MEM_RDATA_I;
        nxt_st.zero = (MEM_RDATA_I == 8'h00);
        nxt_st.state = ST_RUN;
      end
      ST_FLUSH: begin
        // Refuses the stale word while the flush pulse stands
        nxt_st.state = ST_RUN;
      end
      ST_RESET_WAIT: begin
        nxt_st.state = ST_RESET_WAIT;
      end
      default: begin
        nxt_st.state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_ff <= '{state: ST_RUN, accum: ACCUM_RST, bank_sel: BANK_RST, page_latch: PAGE_RST,
                 ptr0: PTR_RST, ptr1: PTR_RST, zero: 1'b0, mem_addr: PTR_RST,
                 mem_wdata: 8'h00, mem_we: 1'b0, mem_re: 1'b0, pop: 1'b0,
                 pc_load: 1'b0, pc_value: 15'h0000, pc_inc: 1'b0, flush: 1'b0,
                 soft_rst: 1'b0, flag_clr: 1'b0, irq_set: 8'h00};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ACCUM_O = st_ff.accum;
  assign BANK_SELECT_O = st_ff.bank_sel;
  assign PAGE_LATCH_O = st_ff.page_latch;
  assign PTR0_O = st_ff.ptr0;
  assign PTR1_O = st_ff.ptr1;
  assign ZERO_O = st_ff.zero;
  assign MEM_ADDR_O = st_ff.mem_addr;
  assign MEM_WDATA_O = st_ff.mem_wdata;
  assign MEM_WE_O = st_ff.mem_we;
  assign MEM_RE_O = st_ff.mem_re;
  assign STACK_POP_O = st_ff.pop;
  assign PC_LOAD_O = st_ff.pc_load;
  assign PC_VALUE_O = st_ff.pc_value;
  assign PC_INC_O = st_ff.pc_inc;
  assign FLUSH_O = st_ff.flush;
  assign SOFT_RESET_O = st_ff.soft_rst;
  assign SOFT_RESET_FLAG_CLR_O = st_ff.flag_clr;
  assign IRQ_CTRL_SET_O = st_ff.irq_set;

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  logic take_bank;
  logic take_page;
  logic take_accum;
  logic take_file;
  logic take_preinc0;
  logic take_rel_store;
  logic take_virt0;
  logic take_load_ind;
  logic take_irq_ret;
  logic take_reset;
  logic take_idle;
  assign take_bank = accept && op_hi == OP_BANK_LIT;
  assign take_page = accept && op_hi == OP_PAGE_LIT;
  assign take_accum = accept && INSTR_I[13:12] == OP_ACCUM_LIT;
  assign take_file = accept && op_hi == OP_MISC && INSTR_I[STORE_FILE_BIT]
                     && INSTR_I[6:1] != 6'h00;
  assign take_preinc0 = accept && is_misc && INSTR_I[6:0] == {MISC_STORE_IND, 1'b0, MODE_PRE_INC};
  assign take_rel_store = accept && is_rel && !INSTR_I[REL_LOAD_BIT];
  assign take_virt0 = accept && op_hi == OP_MISC && INSTR_I[STORE_FILE_BIT]
                      && INSTR_I[6:0] == VIRT_PORT0;
  assign take_load_ind = accept && is_misc && INSTR_I[6:3] == MISC_LOAD_IND;
  assign take_irq_ret = accept && is_misc && INSTR_I[6:0] == MISC_IRQ_RETURN;
  assign take_reset = accept && is_misc && INSTR_I[6:0] == MISC_SOFT_RESET;
  assign take_idle = accept && INSTR_I == {OP_MISC, 1'b0, MISC_IDLE};

  sequence irq_pop_s;
    STACK_POP_O && PC_LOAD_O && PC_VALUE_O == $past(STACK_TOP_I) && IRQ_CTRL_SET_O[IRQ_EN_BIT];
  endsequence
  sequence irq_flush_s;
    FLUSH_O && !READY_O;
  endsequence
  sequence irq_resume_s;
    READY_O && !FLUSH_O && !STACK_POP_O && !PC_LOAD_O;
  endsequence
  sequence load_issue_s;
    MEM_RE_O && !MEM_WE_O && !READY_O;
  endsequence

  chk_bank_load: assert property (take_bank |=> BANK_SELECT_O == $past(INSTR_I[5:0])
    && $stable(ZERO_O)) else $error("bank literal not loaded");
  chk_page_load: assert property (take_page |=> PAGE_LATCH_O == $past(INSTR_I[6:0])
    && $stable(ZERO_O)) else $error("page literal not loaded");
  chk_accum_load: assert property (take_accum |=> ACCUM_O == $past(INSTR_I[7:0])
    && READY_O && $stable(ZERO_O)) else $error("accum literal not loaded");
  chk_file_store: assert property (take_file |=> MEM_WE_O
    && MEM_WDATA_O == $past(ACCUM_O)
    && MEM_ADDR_O == {3'b000, $past(BANK_SELECT_O), $past(INSTR_I[6:0])})
    else $error("file store wrong");
  chk_virt_port: assert property (take_virt0 |=> MEM_WE_O
    && MEM_ADDR_O == $past(PTR0_O) && $stable(PTR0_O))
    else $error("virtual port store wrong");
  chk_pre_inc: assert property (take_preinc0 |=> MEM_WE_O
    && MEM_ADDR_O == PTR0_O && PTR0_O == $past(PTR0_O) + PTR_ONE && $stable(ZERO_O))
    else $error("pre increment store wrong");
  chk_rel_store: assert property (take_rel_store |=> MEM_WE_O
    && $stable(PTR0_O) && $stable(PTR1_O) && $stable(ZERO_O)
    && MEM_ADDR_O == $past(sel_ptr) + {{10{$past(INSTR_I[5])}}, $past(INSTR_I[5:0])})
    else $error("relative store wrong");
  chk_load_ind: assert property (take_load_ind |=> load_issue_s ##1 !READY_O
    ##1 (ACCUM_O == $past(MEM_RDATA_I) && ZERO_O == ($past(MEM_RDATA_I) == 8'h00)))
    else $error("indirect load wrong");
  chk_irq_return: assert property (take_irq_ret
    |=> (irq_pop_s and irq_flush_s) ##1 irq_resume_s)
    else $error("irq return sequence wrong");
  chk_soft_reset: assert property (take_reset |=> SOFT_RESET_O && SOFT_RESET_FLAG_CLR_O
    ##1 !READY_O[*3]) else $error("soft reset wrong");
  chk_stall_hold: assert property (st_ff.state == ST_RESET_WAIT |=> !READY_O
    && !PC_INC_O && !MEM_WE_O) else $error("core left reset wait");
  chk_flag_clear: assert property (SOFT_RESET_O |-> SOFT_RESET_FLAG_CLR_O)
    else $error("soft reset flag not cleared");
  chk_idle_op: assert property (take_idle |=> PC_INC_O && !MEM_WE_O
    && $stable(ACCUM_O) && $stable(BANK_SELECT_O) && $stable(PTR0_O) && $stable(PTR1_O)
    && $stable(ZERO_O)) else $error("idle op changed state");
endmodule : literal_move_return_exec

// File: hw/lmr_pkg.sv
// Purpose: Shared constants for the literal, move and return executor.
// Assumes: 14-bit instruction words, one accepted word per valid clock.
// Notes: Opcode layout is local to this core slice.
package lmr_pkg;
  localparam int INSTR_W = 14;
  localparam int ADDR_W = 16;
  // Opcode fields
  localparam logic [1:0] OP_ACCUM_LIT = 2'h3;
  localparam logic [5:0] OP_MISC = 6'h00;
  localparam logic [5:0] OP_PAGE_LIT = 6'h01;
  localparam logic [5:0] OP_BANK_LIT = 6'h02;
  localparam logic [5:0] OP_REL_IND = 6'h03;
  localparam logic [6:0] MISC_IDLE = 7'h00;
  localparam logic [6:0] MISC_SOFT_RESET = 7'h01;
  localparam logic [6:0] MISC_IRQ_RETURN = 7'h09;
  localparam logic [3:0] MISC_STORE_IND = 4'h2;
  localparam logic [3:0] MISC_LOAD_IND = 4'h3;
  // Field positions
  localparam int STORE_FILE_BIT = 7;
  localparam int REL_LOAD_BIT = 7;
  localparam int REL_SEL_BIT = 6;
  localparam int IND_SEL_BIT = 2;
  localparam int IRQ_EN_BIT = 7;
  // Pointer handling modes
  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;
  // File addresses of the virtual indirect ports
  localparam logic [6:0] VIRT_PORT0 = 7'h00;
  localparam logic [6:0] VIRT_PORT1 = 7'h01;
  // Reset values, pointer step and irq return set mask
  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic [5:0] BANK_RST = 6'h00;
  localparam logic [6:0] PAGE_RST = 7'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] PTR_ONE = 16'h0001;
  localparam logic [7:0] IRQ_SET_MASK = 8'h80;
endpackage : lmr_pkg

// File: hw/ptr_step.sv
// Purpose: Effective address and next value of one indirect pointer.
// Assumes: Purely combinational, 16-bit wrap by truncation.
// Notes: Shared by every indirect load and store except the virtual port stores, which use the pointer as is.
`timescale 1ns/100ps
module ptr_step
  import lmr_pkg::*;
(
  // Pointer and mode
  input wire logic [15:0] ptr_i,
  input wire logic [1:0] mode_i,
  input wire logic rel_i,
  input wire logic [5:0] off_i,
  // Results
  output logic [15:0] eff_o,
  output logic [15:0] nxt_ptr_o
);
  logic [15:0] upd;
  always_comb begin
    // Modulo 65536 by width
    upd = mode_i[0] ? ptr_i - PTR_ONE : ptr_i + PTR_ONE;
    if (rel_i) begin
      eff_o = ptr_i + {{10{off_i[5]}}, off_i};
      nxt_ptr_o = ptr_i;
    end else begin
      eff_o = mode_i[1] ? ptr_i : upd;
      nxt_ptr_o = upd;
    end
  end
endmodule : ptr_step

// File: sim/test_literal_move_return_exec.sv
// Purpose: Self-checking bench for the literal, move and return executor.
// Assumes: Bench plays fetch, data memory and stack; memory answers in the cycle after a read.
// Notes: Outputs are sampled 1 ns after the edge so that register updates have landed.
`timescale 1ns/100ps
module test_literal_move_return_exec;
  import lmr_pkg::*;
  logic CLK_I;
  logic RESETN_I;
  logic [INSTR_W-1:0] INSTR_I;
  logic INSTR_VALID_I;
  logic [7:0] MEM_RDATA_I;
  logic [14:0] STACK_TOP_I;
  logic READY_O, ZERO_O, MEM_WE_O, MEM_RE_O, STACK_POP_O, PC_LOAD_O, PC_INC_O, FLUSH_O;
  logic SOFT_RESET_O, SOFT_RESET_FLAG_CLR_O;
  logic [7:0] ACCUM_O, MEM_WDATA_O, IRQ_CTRL_SET_O;
  logic [5:0] BANK_SELECT_O;
  logic [6:0] PAGE_LATCH_O;
  logic [15:0] PTR0_O, PTR1_O, MEM_ADDR_O;
  logic [14:0] PC_VALUE_O;
  int mismatches, check_count, cycles;
  logic [15:0] p [2];
  logic [15:0] ea;
  logic [7:0] acc;
  logic [1:0] modes [6];

  literal_move_return_exec u_dut (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .INSTR_I(INSTR_I),
    .INSTR_VALID_I(INSTR_VALID_I), .READY_O(READY_O), .ACCUM_O(ACCUM_O),
    .BANK_SELECT_O(BANK_SELECT_O), .PAGE_LATCH_O(PAGE_LATCH_O), .PTR0_O(PTR0_O),
    .PTR1_O(PTR1_O), .ZERO_O(ZERO_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O),
    .MEM_WE_O(MEM_WE_O), .MEM_RE_O(MEM_RE_O), .MEM_RDATA_I(MEM_RDATA_I),
    .STACK_TOP_I(STACK_TOP_I), .STACK_POP_O(STACK_POP_O), .PC_LOAD_O(PC_LOAD_O),
    .PC_VALUE_O(PC_VALUE_O), .PC_INC_O(PC_INC_O), .FLUSH_O(FLUSH_O),
    .SOFT_RESET_O(SOFT_RESET_O), .SOFT_RESET_FLAG_CLR_O(SOFT_RESET_FLAG_CLR_O),
    .IRQ_CTRL_SET_O(IRQ_CTRL_SET_O));

  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end

  task automatic conclude;
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Offer one word; returns in the cycle after it was taken
  task automatic issue(input logic [13:0] w, input logic [7:0] rd);
    @(posedge CLK_I);
    INSTR_I <= w;
    INSTR_VALID_I <= 1'b1;
    MEM_RDATA_I <= rd;
    @(posedge CLK_I);
    INSTR_VALID_I <= 1'b0;
    INSTR_I <= ~w;
    #1;
  endtask : issue

  task automatic step;
    @(posedge CLK_I);
    #1;
  endtask : step

  // Hang guard, generous against a run of under 200 cycles
  always @(posedge CLK_I) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    RESETN_I = 1'b0;
    INSTR_I = 14'h0000;
    INSTR_VALID_I = 1'b0;
    MEM_RDATA_I = 8'h00;
    STACK_TOP_I = 15'h5A3C;
    mismatches = 0;
    check_count = 0;
    p[0] = 16'h0000;
    p[1] = 16'h0000;
    modes = '{MODE_PRE_INC, MODE_PRE_DEC, MODE_POST_INC, MODE_POST_DEC, MODE_PRE_DEC,
      MODE_PRE_INC};
    repeat (20) @(posedge CLK_I);
    RESETN_I <= 1'b1;
    #1;
    check(READY_O, 1'b1);
    check(PTR0_O, 16'h0000);
    issue(14'h023F, 8'h00);
    check(BANK_SELECT_O, 6'h3F);
    check(ZERO_O, 1'b0);
    issue(14'h017F, 8'h00);
    check(PAGE_LATCH_O, 7'h7F);
    check(BANK_SELECT_O, 6'h3F);
    issue(14'h30A5, 8'h00);
    check(ACCUM_O, 8'hA5);
    check(PC_INC_O, 1'b1);
    acc = 8'hA5;
    issue(14'h00A5, 8'h00);
    check(MEM_WE_O, 1'b1);
    check(MEM_ADDR_O, 16'h1FA5);
    check(MEM_WDATA_O, acc);
    for (int i = 0; i < 6; i++) begin
      ea = modes[i][0] ? p[i%2] - 16'h0001 : p[i%2] + 16'h0001;
      issue({7'h00, MISC_STORE_IND, i[0], modes[i]}, 8'h00);
      check(MEM_WE_O, 1'b1);
      check(MEM_ADDR_O, modes[i][1] ? p[i%2] : ea);
      p[i%2] = ea;
      check(PTR0_O, p[0]);
      check(PTR1_O, p[1]);
      check(ZERO_O, 1'b0);
    end
    issue(14'h0080, 8'h00);
    check(MEM_ADDR_O, p[0]);
    check(PTR0_O, p[0]);
    issue(14'h039F, 8'h00);
    check(MEM_RE_O, 1'b1);
    check(MEM_ADDR_O, p[0] + 16'h001F);
    check(READY_O, 1'b0);
    step();
    step();
    check(ACCUM_O, 8'h00);
    check(ZERO_O, 1'b1);
    check(PTR0_O, p[0]);
    acc = 8'h00;
    issue(14'h0360, 8'hFF);
    check(MEM_ADDR_O, p[1] - 16'h0020);
    check(MEM_WDATA_O, acc);
    check(PTR1_O, p[1]);
    check(ZERO_O, 1'b1);
    issue({7'h00, MISC_LOAD_IND, 1'b1, MODE_POST_INC}, 8'hC3);
    check(MEM_ADDR_O, p[1]);
    check(PTR1_O, 16'h0000);
    step();
    step();
    check(ACCUM_O, 8'hC3);
    check(ZERO_O, 1'b0);
    issue(14'h0000, 8'h00);
    check(PC_INC_O, 1'b1);
    check(MEM_WE_O, 1'b0);
    check(MEM_RE_O, 1'b0);
    check(ACCUM_O, 8'hC3);
    check({BANK_SELECT_O, PAGE_LATCH_O}, {6'h3F, 7'h7F});
    issue(14'h0009, 8'h00);
    check(STACK_POP_O, 1'b1);
    check(PC_LOAD_O, 1'b1);
    check(PC_VALUE_O, 15'h5A3C);
    check(IRQ_CTRL_SET_O, 8'h80);
    check(READY_O, 1'b0);
    check(FLUSH_O, 1'b1);
    step();
    check(FLUSH_O, 1'b0);
    check(READY_O, 1'b1);
    check(PC_LOAD_O, 1'b0);
    step();
    check(READY_O, 1'b1);
    issue(14'h0001, 8'h00);
    check(SOFT_RESET_O, 1'b1);
    check(SOFT_RESET_FLAG_CLR_O, 1'b1);
    issue(14'h3011, 8'h00);
    check(ACCUM_O, 8'hC3);
    check(READY_O, 1'b0);
    // Outside logic must answer the request with a real reset
    @(posedge CLK_I);
    RESETN_I <= 1'b0;
    step();
    check(ACCUM_O, 8'h00);
    check(READY_O, 1'b1);
    @(posedge CLK_I);
    RESETN_I <= 1'b1;
    issue(14'h3042, 8'h00);
    check(ACCUM_O, 8'h42);
    conclude();
  end
endmodule : test_literal_move_return_exec
